// >>> rtl/pulse_gen.sv
`timescale 1ns/1ps
// Functional notes
// - rising start edge begins pulse on true and complementary outputs.
// - width equals inherent width plus address times increment step.
// - address zero gives shortest pulse, nominally 14 ns within 2 ns; code gives 2 cycles, 20 ns.
// - increment fixed per variant, 0.25 ns to 800 us; wide max 50 us.
// - early stop during pulse ends it before programmed width.
// - start edges during a pulse are ignored.
// - after a pulse a recovery interval passes before new start accepted.
// - in latched mode address is stored internally, inputs may change.
module pulse_gen #(
    parameter bit WIDE = 1'b1 // 1: 12-bit variant, 0: 8-bit variant
) (
    // clock and reset
    input  wire logic                              clk,
    input  wire logic                              rst,
    // control pins from driving logic
    input  wire logic                              start_edge_input,
    input  wire logic                              early_stop_input,
    input  wire logic                              address_hold_select,
    input  wire logic [pulse_gen_pkg::ADDR_W-1:0]  address_in,
    // pulse outputs
    output logic                                   pulse_output,
    output logic                                   complement_pulse_output,
    // status
    output logic                                   busy
);
    typedef enum {IDLE, PULSE, RECOVER} state_t;

    localparam int RAW_W = pulse_gen_pkg::ADDR_W + 3;

    logic [RAW_W-1:0]                 raw;
    logic [RAW_W-1:0]                 sync;
    pulse_gen_pkg::pins_t             pins;
    pulse_gen_pkg::pulse_out_t        outs;
    logic                             start_prev;
    logic                             hold_prev;
    logic                             start_rise;
    logic                             hold_fall;
    logic [pulse_gen_pkg::ADDR_W-1:0] addr_latched;
    logic [pulse_gen_pkg::ADDR_W-1:0] addr_used;
    logic [pulse_gen_pkg::ADDR_W-1:0] addr_masked;
    logic [31:0]                      width_cyc;
    logic [31:0]                      count;
    logic [3:0]                       rec_count;
    state_t                           state;

    // all pins come from outside the clock domain
    assign raw = {start_edge_input, early_stop_input,
                  address_hold_select, address_in};

    pin_sync #(
        .W(RAW_W)
    ) u_sync (
        .clk    (clk),
        .rst    (rst),
        .pin    (raw),
        .settled(sync)
    );

    assign pins = pulse_gen_pkg::pins_t'(sync);

    // edge detection on settled pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            start_prev <= 1'b0;
            hold_prev  <= 1'b0;
        end else begin
            start_prev <= pins.start;
            hold_prev  <= pins.hold_sel;
        end
    end

    assign start_rise = pins.start & ~start_prev;
    assign hold_fall  = ~pins.hold_sel & hold_prev;

    // latched store: inputs free to change once held
    // capture on fall of hold select
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_latched <= pulse_gen_pkg::ADDR_RESET;
        end else if (pins.hold_sel || hold_fall) begin
            addr_latched <= pins.addr;
        end
    end

    assign addr_used   = pins.hold_sel ? pins.addr : addr_latched;
    // narrow variant uses only low address bits
    assign addr_masked = WIDE ? addr_used
                              : {{(pulse_gen_pkg::ADDR_W -
                                   pulse_gen_pkg::NARROW_ADDR_W){1'b0}},
                                 addr_used[pulse_gen_pkg::NARROW_ADDR_W-1:0]};

    assign width_cyc = 32'(pulse_gen_pkg::INHERENT_CYC)
                     + 32'(addr_masked) * 32'(pulse_gen_pkg::INC_CYC);

    // pulse sequencing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state     <= IDLE;
            count     <= 32'h0000_0000;
            rec_count <= 4'h0;
        end else begin
            case (state)
                IDLE: begin
                    if (start_rise && !pins.stop) begin
                        state <= PULSE;
                        count <= 32'h0000_0001;
                    end
                end
                PULSE: begin
                    if (pins.stop) begin
                        state     <= RECOVER;
                        rec_count <= 4'h1;
                    end else if (count >= width_cyc) begin
                        state     <= RECOVER;
                        rec_count <= 4'h1;
                    end else begin
                        count <= count + 32'h0000_0001;
                    end
                end
                RECOVER: begin
                    if (rec_count >= pulse_gen_pkg::RECOVER_CYC) begin
                        state <= IDLE;
                    end else begin
                        rec_count <= rec_count + 4'h1;
                    end
                end
                default: state <= IDLE;
            endcase
        end
    end

    // true and complementary outputs from flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outs <= 2'b01;
        end else begin
            outs.true_out <= (state == IDLE && start_rise && !pins.stop) ||
                             (state == PULSE && !pins.stop &&
                              count < width_cyc);
            outs.comp_out <= !((state == IDLE && start_rise &&
                                !pins.stop) ||
                               (state == PULSE && !pins.stop &&
                                count < width_cyc));
        end
    end

    assign pulse_output            = outs.true_out;
    assign complement_pulse_output = outs.comp_out;
    assign busy                    = (state != IDLE);

    property p_complement;
        @(posedge clk) disable iff (rst)
        complement_pulse_output == !pulse_output;
    endproperty
    a_complement: assert property (p_complement)
        else $error("outputs not complementary");

    // rising edge in idle starts pulse next cycle
    property p_start;
        @(posedge clk) disable iff (rst)
        (state == IDLE && start_rise && !pins.stop) |=> pulse_output;
    endproperty
    a_start: assert property (p_start)
        else $error("pulse did not start");

    sequence s_begin_zero;
        state == IDLE && start_rise && !pins.stop &&
        width_cyc == 32'(pulse_gen_pkg::INHERENT_CYC);
    endsequence
    // two cycles high, then low
    property p_shortest;
        @(posedge clk) disable iff (rst)
        s_begin_zero ##1 (!pins.stop && $stable(width_cyc))
            |-> pulse_output[*2] ##1 !pulse_output;
    endproperty
    a_shortest: assert property (p_shortest)
        else $error("shortest pulse width wrong");

    // pulse ends when counted width reached
    property p_width_end;
        @(posedge clk) disable iff (rst)
        (state == PULSE && count >= width_cyc) |=> !pulse_output;
    endproperty
    a_width_end: assert property (p_width_end)
        else $error("pulse longer than width");

    // early stop drops the pulse next cycle
    property p_stop;
        @(posedge clk) disable iff (rst)
        (state == PULSE && pins.stop) |=> (!pulse_output && state == RECOVER);
    endproperty
    a_stop: assert property (p_stop)
        else $error("early stop ignored");

    property p_no_retrigger;
        @(posedge clk) disable iff (rst)
        (state == PULSE && !pins.stop && count < width_cyc)
            |=> (state == PULSE && count == $past(count) + 32'd1);
    endproperty
    a_no_retrigger: assert property (p_no_retrigger)
        else $error("pulse restarted");

    sequence s_enter_recover;
        state == PULSE ##1 state == RECOVER;
    endsequence
    property p_recover;
        @(posedge clk) disable iff (rst)
        s_enter_recover |-> (state == RECOVER && !pulse_output)[*2];
    endproperty
    a_recover: assert property (p_recover)
        else $error("recovery cut short");

    // hold value after falling edge of select
    property p_hold;
        @(posedge clk) disable iff (rst)
        (!pins.hold_sel && !hold_fall) |=> $stable(addr_latched);
    endproperty
    a_hold: assert property (p_hold)
        else $error("latched address changed");
endmodule // pulse_gen

// >>> rtl/pulse_gen_pkg.sv
package pulse_gen_pkg;

    // address width of the wide variant; the narrow variant uses fewer bits
    localparam int ADDR_W          = 12;
    localparam int NARROW_ADDR_W   = 8;
    localparam int CLK_PERIOD_NS   = 10;

    // inherent width at address zero, nominal and tolerance
    localparam int INHERENT_NS     = 14;
    localparam int INHERENT_TOL_PS = 2000;
    // shortest width rounds up, but at least one cycle
    localparam int INHERENT_CYC_I  =
        (INHERENT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] INHERENT_CYC =
        16'(INHERENT_CYC_I < 1 ? 1 : INHERENT_CYC_I);

    // width step per address count
    localparam int INC_NS          = 20;
    localparam int INC_MIN_PS      = 250;
    localparam int INC_MAX_NS      = 800000;
    localparam int INC_MAX_WIDE_NS = 50000;
    localparam int INC_CYC_I       = INC_NS / CLK_PERIOD_NS;
    localparam logic [15:0] INC_CYC =
        16'(INC_CYC_I < 1 ? 1 : INC_CYC_I);

    // recovery interval after each pulse
    localparam int RECOVER_NS      = 20;
    localparam int RECOVER_CYC_I   =
        (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] RECOVER_CYC =
        4'(RECOVER_CYC_I < 1 ? 1 : RECOVER_CYC_I);

    // reset value of the held address
    localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;

    // pins as seen by the core after synchronising
    typedef struct packed {
        logic              start;
        logic              stop;
        logic              hold_sel;
        logic [ADDR_W-1:0] addr;
    } pins_t;

    // the two output forms of the pulse
    typedef struct packed {
        logic true_out;
        logic comp_out;
    } pulse_out_t;

endpackage

// >>> rtl/pin_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; change taken when stages two and three agree
module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // raw pin and settled value
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] settled
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // shift chain; s1 only feeds s2
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // accept per bit only when two later stages agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            settled <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    settled[i] <= s3[i];
                end
            end
        end
    end
endmodule // pin_sync

// >>> dv/pulse_driver.sv
`timescale 1ns/1ps
// controlling logic on the pin side of the pulse generator
module pulse_driver (
    // clock and status
    input  wire logic                         clk,
    input  wire logic                         busy,
    // control pins
    output logic                              start_edge_input,
    output logic                              early_stop_input,
    output logic                              address_hold_select,
    output logic [pulse_gen_pkg::ADDR_W-1:0]  address_in
);
    logic scramble;

    // pins idle at time zero
    initial begin
        start_edge_input = 1'b0;
        early_stop_input = 1'b0;
        address_hold_select = 1'b1;
        address_in = 12'h000;
        scramble = 1'b0;
    end

    // a released shared bus changes every cycle
    always @(posedge clk) begin
        if (scramble) address_in <= ~address_in;
    end

    // program an address and raise the start pin
    task automatic fire(input logic [11:0] a, input bit latched,
                        output bit ok);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        ok = (n < 20000);
        @(posedge clk);
        scramble <= 1'b0;
        @(posedge clk);
        // address stays put until the next fire unless latched mode releases the bus to toggle
        address_in <= a;
        address_hold_select <= 1'b1;
        if (latched) begin
            repeat (6) @(posedge clk);
            address_hold_select <= 1'b0;
            repeat (6) @(posedge clk);
            scramble <= 1'b1;
        end
        start_edge_input <= 1'b1;
        repeat (6) @(posedge clk);
        start_edge_input <= 1'b0;
    endtask

    // extra start edge, long enough to pass the synchroniser
    task automatic poke();
        @(posedge clk);
        start_edge_input <= 1'b1;
        repeat (6) @(posedge clk);
        start_edge_input <= 1'b0;
    endtask

    // early stop pulse
    task automatic stop_early();
        @(posedge clk);
        early_stop_input <= 1'b1;
        repeat (6) @(posedge clk);
        early_stop_input <= 1'b0;
    endtask
endmodule // pulse_driver

// >>> dv/tb.sv
`timescale 1ns/1ps
// self-checking bench for the pulse generator
module tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        start_edge_input;
    logic        early_stop_input;
    logic        address_hold_select;
    logic [11:0] address_in;
    logic        pulse_output;
    logic        complement_pulse_output;
    logic        busy;
    logic [15:0] failures = 16'h0000;
    logic [15:0] comparisons = 16'h0000;
    logic        narrow_pulse;
    logic        narrow_prev = 1'b0;
    logic [15:0] narrow_w    = 16'h0000;

    // 100 MHz clock
    always #5 clk = ~clk;

    pulse_driver drv (
        .clk                 (clk),
        .busy                (busy),
        .start_edge_input    (start_edge_input),
        .early_stop_input    (early_stop_input),
        .address_hold_select (address_hold_select),
        .address_in          (address_in)
    );

    pulse_gen #(.WIDE(1'b1)) dut (
        .clk                     (clk),
        .rst                     (rst),
        .start_edge_input        (start_edge_input),
        .early_stop_input        (early_stop_input),
        .address_hold_select     (address_hold_select),
        .address_in              (address_in),
        .pulse_output            (pulse_output),
        .complement_pulse_output (complement_pulse_output),
        .busy                    (busy)
    );

    // narrow variant shares the pins; only low address bits count
    pulse_gen #(.WIDE(1'b0)) dut_narrow (
        .clk                     (clk),
        .rst                     (rst),
        .start_edge_input        (start_edge_input),
        .early_stop_input        (early_stop_input),
        .address_hold_select     (address_hold_select),
        .address_in              (address_in),
        .pulse_output            (narrow_pulse),
        .complement_pulse_output (),
        .busy                    ()
    );

    // width of the last narrow pulse, sampled away from the launch edge
    always @(negedge clk) begin
        narrow_prev <= narrow_pulse;
        if (narrow_pulse && !narrow_prev)
            narrow_w <= 16'h0001;
        else if (narrow_pulse)
            narrow_w <= narrow_w + 16'h0001;
    end

    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // report and end the run
    task automatic stop_test();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures === 16'h0000 && comparisons !== 16'h0000)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // wait for a pulse and count its cycles
    task automatic measure(output logic [15:0] w);
        int n;
        n = 0;
        w = 16'h0000;
        @(posedge clk);
        #1;
        while (pulse_output !== 1'b1 && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 60) begin
            failures++;
            stop_test();
        end
        while (pulse_output === 1'b1 && w < 16'h3000) begin
            check({15'h0, complement_pulse_output}, 16'h0000);
            @(posedge clk);
            #1;
            w++;
        end
        // a pulse that never ends closes the run
        if (w == 16'h3000) begin
            failures++;
            stop_test();
        end
        check({15'h0, complement_pulse_output}, 16'h0001);
    endtask

    // one pulse of a given address, then its recovery
    task automatic width_case(input logic [11:0] a, input bit latched);
        logic [15:0] w;
        logic [15:0] r;
        bit          ok;
        r = 16'h0000;
        fork
            drv.fire(a, latched, ok);
            measure(w);
        join
        check(w, pulse_gen_pkg::INHERENT_CYC +
                 16'(a) * pulse_gen_pkg::INC_CYC);
        check(narrow_w, pulse_gen_pkg::INHERENT_CYC +
                        16'(a[7:0]) * pulse_gen_pkg::INC_CYC);
        while (busy === 1'b1 && r < 16'h0010) begin
            @(posedge clk);
            #1;
            r++;
        end
        check(r, 16'(pulse_gen_pkg::RECOVER_CYC));
        check({15'h0, ok}, 16'h0001);
        // a wait that ran out closes the run
        if (!ok || r == 16'h0010) stop_test();
    endtask

    // outputs while reset is held
    task automatic t_reset_levels();
        check({13'h0, pulse_output, complement_pulse_output, busy},
              16'h0002);
    endtask

    // widths at the corners of the address range
    task automatic t_widths();
        logic [11:0] tbl [5] = '{12'h000, 12'h001, 12'h002, 12'h0FF, 12'hFFF};
        foreach (tbl[i]) width_case(tbl[i], 1'b0);
    endtask

    // latched address survives a toggling bus
    task automatic t_latched();
        width_case(12'h005, 1'b1);
    endtask

    // start edges during a pulse
    task automatic t_retrigger();
        logic [15:0] w;
        logic [15:0] extra;
        bit          ok;
        extra = 16'h0000;
        fork
            drv.fire(12'h014, 1'b0, ok);
            measure(w);
            begin
                repeat (20) @(posedge clk);
                drv.poke();
            end
        join
        check(w, pulse_gen_pkg::INHERENT_CYC +
                 16'h0014 * pulse_gen_pkg::INC_CYC);
        repeat (30) begin
            @(posedge clk);
            #1;
            if (pulse_output !== 1'b0) extra++;
        end
        check(extra, 16'h0000);
    endtask

    // early stop cuts a long pulse
    task automatic t_early_stop();
        logic [15:0] w;
        bit          ok;
        fork
            drv.fire(12'h0C8, 1'b0, ok);
            measure(w);
            begin
                repeat (25) @(posedge clk);
                drv.stop_early();
            end
        join
        check({15'h0, (w > 16'h0008 && w < 16'h0028)}, 16'h0001);
        width_case(12'h000, 1'b0);
    endtask

    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        #1;
        t_reset_levels();
        @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_widths();
        t_latched();
        t_retrigger();
        t_early_stop();
        stop_test();
    end
endmodule // tb
